// *** hw/sadc_core.sv ***
// Serial interface logic of a multi-channel successive-approximation converter.
`timescale 1ns/1ns
`include "sadc_map.svh"

// Notes on behaviour
// R01: Input bit is taken on each rising serial clock edge.
// R02: Input bits are ignored while chip select is high.
// R03: Output bit changes on each falling serial clock edge.
// R04: Output is released while chip select is high, driven while low.
// R05: Internal clock mode: strobe low during conversion, high when done.
// R06: External clock mode: strobe high two periods before the first result bit.
// R07: External clock mode releases strobe with chip select high; internal always drives.
// R08: Host keeps serial clock duty between 45% and 55% in external mode.
// R09: Shutdown low shuts down everything; floating leaves device working.
// R10: Shutdown high powers down only the reference generator.
// R11: Host waits for strobe rise before clocking results in internal mode.
// R12: Conversion time is conversion clock cycles times clock period.
// R13: Host sends a fresh control byte before every conversion.
// R14: Tracking starts after sixth control bit, hold after eighth, on falling edges.
// R15: Bit counter restarts whenever chip select goes high.
module sadc_core #(
  parameter int CONV_CYCLES = `SADC_CONV_TIME_NS / `SADC_CLK_PERIOD_NS
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic din_i,
  input wire logic [1:0] shutdown_level_i,
  input wire logic int_clock_mode_i,
  input wire logic [`SADC_DATA_W-1:0] sample_data_i,
  output logic dout_o,
  output logic dout_oe_n_o,
  output logic conversion_strobe_o,
  output logic conversion_strobe_oe_n_o,
  output logic track_o,
  output logic full_shutdown_o,
  output logic reference_generator_off_o,
  output logic [`SADC_DATA_W-1:0] control_byte_o,
  output logic control_valid_o
);
  import sadc_pkg::*;

  localparam logic [`SADC_CONV_CNT_W-1:0] CONV_LAST = `SADC_CONV_CNT_W'(CONV_CYCLES - 1);

  sadc_state_t s_q;
  sadc_state_t s_d;
  logic [`SADC_SYNC_W-1:0] pins_s;
  logic cs_s;
  logic sclk_s;
  logic din_s;
  logic [1:0] three_level_shutdown_input_s;
  logic rise_w;
  logic fall_w;
  logic int_done_w;
  logic start_w;

  // The shutdown level is sampled bit by bit, so a transition may show one
  // intermediate code for a cycle; the outputs follow it with that lag.
  sadc_sync #(
    .W(`SADC_SYNC_W),
    .RST(`SADC_SYNC_RST)
  ) u_sync (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i),
    .async_i({shutdown_level_i, din_i, sclk_i, cs_n_i}),
    .sync_o(pins_s)
  );

  assign cs_s = pins_s[0];
  assign sclk_s = pins_s[1];
  assign din_s = pins_s[2];
  assign three_level_shutdown_input_s = pins_s[4:3];
  assign rise_w = sclk_s & ~s_q.sclk_p;
  assign fall_w = ~sclk_s & s_q.sclk_p;

  always_comb begin
    s_d = s_q;
    int_done_w = 1'b0;
    start_w = 1'b0;
    s_d.sclk_p = sclk_s;
    s_d.dout_oe_n = cs_s; // R04
    s_d.full_sd = (three_level_shutdown_input_s == `SADC_THREE_LEVEL_SHUTDOWN_INPUT_LOW); // R09
    s_d.ref_pd = (three_level_shutdown_input_s == `SADC_THREE_LEVEL_SHUTDOWN_INPUT_HIGH); // R10
    s_d.ctrl_valid = 1'b0;
    unique case (s_q.phase)
      SADC_IDLE, SADC_SHIFT_OUT: begin
        if (rise_w && !cs_s && s_q.bit_cnt < `SADC_CTRL_BITS) begin
          s_d.ctrl_sr = {s_q.ctrl_sr[`SADC_DATA_W-2:0], din_s}; // R01
          s_d.bit_cnt = s_q.bit_cnt + 4'h1;
        end
        if (fall_w && s_q.phase == SADC_SHIFT_OUT) begin
          s_d.res_sr = {s_q.res_sr[`SADC_DATA_W-2:0], 1'b0};
          if (s_q.out_cnt < `SADC_OUT_LAST) begin
            s_d.dout = s_q.res_sr[`SADC_DATA_W-2]; // R03
            s_d.out_cnt = s_q.out_cnt + 4'h1;
          end else begin
            s_d.dout = 1'b0;
          end
        end
        if (fall_w && !cs_s && s_q.bit_cnt == `SADC_TRACK_BIT) begin
          s_d.track = 1'b1; // R14
        end
        if (fall_w && !cs_s && s_q.bit_cnt == `SADC_CTRL_BITS) begin
          start_w = 1'b1;
          s_d.track = 1'b0; // R14
          s_d.ctrl_byte = s_q.ctrl_sr;
          s_d.bit_cnt = '0;
          s_d.ext_mode = ~int_clock_mode_i;
          s_d.pulse_cnt = '0;
          s_d.conv_cnt = '0;
          if (int_clock_mode_i) begin
            s_d.phase = SADC_INT_CONV;
            s_d.strobe = 1'b0; // R05
          end else begin
            s_d.phase = SADC_EXT_CONV;
            s_d.strobe = 1'b1; // R06
          end
        end
      end
      SADC_EXT_CONV: begin
        // The serial clock paces this phase, so its duty cycle sets the settling margin.
        if (fall_w) begin
          s_d.pulse_cnt = s_q.pulse_cnt + 2'h1;
          if (s_q.pulse_cnt == `SADC_STROBE_PERIODS - 2'h1) begin
            s_d.strobe = 1'b0; // R06
            s_d.res_sr = sample_data_i;
            s_d.dout = sample_data_i[`SADC_DATA_W-1];
            s_d.out_cnt = '0;
            s_d.phase = SADC_SHIFT_OUT;
          end
        end
      end
      SADC_INT_CONV: begin
        s_d.conv_cnt = s_q.conv_cnt + `SADC_CONV_CNT_W'(1);
        if (s_q.conv_cnt == CONV_LAST) begin
          int_done_w = 1'b1; // R12
          s_d.strobe = 1'b1; // R05
          // The first result bit is placed in the same cycle as the strobe rises, so a host
          // that waits for the strobe samples it on its first rising edge.
          s_d.res_sr = sample_data_i; // R11
          s_d.dout = sample_data_i[`SADC_DATA_W-1];
          s_d.out_cnt = '0;
          s_d.bit_cnt = '0;
          s_d.phase = SADC_SHIFT_OUT;
        end
      end
    endcase
    s_d.ctrl_valid = start_w;
    // An internal conversion runs on to its end even if chip select rises.
    if (cs_s && s_q.phase != SADC_INT_CONV) begin
      s_d.phase = SADC_IDLE; // R02
      s_d.bit_cnt = '0; // R15
      s_d.track = 1'b0;
      s_d.strobe = ~s_q.ext_mode;
    end
    if (s_q.full_sd) begin
      s_d.phase = SADC_IDLE; // R09
      s_d.bit_cnt = '0;
      s_d.track = 1'b0;
      s_d.strobe = ~s_q.ext_mode;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q <= '{phase: SADC_IDLE, strobe: 1'b1, dout_oe_n: 1'b1, sclk_p: 1'b0, default: '0};
    end else if (clk_en_i) begin
      s_q <= s_d;
    end
  end

  assign dout_o = s_q.dout;
  assign dout_oe_n_o = s_q.dout_oe_n;
  assign conversion_strobe_o = s_q.strobe;
  assign conversion_strobe_oe_n_o = s_q.ext_mode & cs_s; // R07
  assign track_o = s_q.track;
  assign full_shutdown_o = s_q.full_sd;
  assign reference_generator_off_o = s_q.ref_pd;
  assign control_byte_o = s_q.ctrl_byte;
  assign control_valid_o = s_q.ctrl_valid;

  // Helper: falling edges seen while the external-mode strobe is high.
  logic [1:0] pulse_seen_q;
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pulse_seen_q <= 2'h0;
    end else if (clk_en_i) begin
      if (!s_q.strobe || !s_q.ext_mode) begin
        pulse_seen_q <= 2'h0;
      end else if (fall_w) begin
        pulse_seen_q <= pulse_seen_q + 2'h1;
      end
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  sample_rise_a: assert property ( // R01
    clk_en_i && rise_w && !cs_s && s_q.phase == SADC_IDLE && s_q.bit_cnt < `SADC_CTRL_BITS
    |=> s_q.ctrl_sr[0] == $past(din_s) && s_q.bit_cnt == $past(s_q.bit_cnt) + 4'h1)
    else $error("Input bit not shifted on rising serial clock.");

  cs_ignore_a: assert property ( // R02
    clk_en_i && cs_s && s_q.phase != SADC_INT_CONV |=> s_q.bit_cnt == 4'h0 && !track_o)
    else $error("Bits counted while chip select high.");

  dout_fall_a: assert property ( // R03
    $changed(dout_o) |-> $past(clk_en_i) && ($past(fall_w) || $past(int_done_w)))
    else $error("Serial output changed away from a falling edge.");

  dout_hiz_a: assert property ( // R04
    clk_en_i |=> dout_oe_n_o == $past(cs_s))
    else $error("Serial output enable does not follow chip select.");

  int_strobe_a: assert property ( // R05
    s_q.phase == SADC_INT_CONV |-> !conversion_strobe_o)
    else $error("Internal-mode strobe high during conversion.");

  int_done_a: assert property ( // R05
    int_done_w && clk_en_i && !s_q.full_sd |=> conversion_strobe_o && s_q.phase == SADC_SHIFT_OUT)
    else $error("Internal-mode strobe did not rise at conversion end.");

  ext_pulse_a: assert property ( // R06
    $fell(conversion_strobe_o) && s_q.ext_mode && s_q.phase == SADC_SHIFT_OUT
    |-> pulse_seen_q == `SADC_STROBE_PERIODS && dout_o == $past(sample_data_i[`SADC_DATA_W-1]))
    else $error("External-mode strobe pulse not two periods.");

  strobe_hiz_a: assert property ( // R07
    !s_q.ext_mode |-> !conversion_strobe_oe_n_o)
    else $error("Internal-mode strobe released.");

  shutdown_low_a: assert property ( // R09
    clk_en_i |=> full_shutdown_o == ($past(three_level_shutdown_input_s) == `SADC_THREE_LEVEL_SHUTDOWN_INPUT_LOW))
    else $error("Full shutdown does not follow shutdown level.");

  ref_off_a: assert property ( // R10
    clk_en_i |=> reference_generator_off_o == ($past(three_level_shutdown_input_s) == `SADC_THREE_LEVEL_SHUTDOWN_INPUT_HIGH)
    && !(reference_generator_off_o && full_shutdown_o))
    else $error("Reference power-down does not follow shutdown level.");

  conv_len_a: assert property ( // R12
    int_done_w |-> s_q.conv_cnt == CONV_LAST && s_q.phase == SADC_INT_CONV)
    else $error("Internal conversion length wrong.");

  track_start_a: assert property ( // R14
    $rose(track_o) |-> $past(fall_w) && $past(s_q.bit_cnt) == `SADC_TRACK_BIT)
    else $error("Tracking began at the wrong edge.");

  hold_start_a: assert property ( // R14
    $rose(control_valid_o) |-> !track_o && $past(s_q.bit_cnt) == `SADC_CTRL_BITS)
    else $error("Hold not entered after the eighth bit.");

  // A low clock enable must hold every state bit, even in the middle of a frame.
  freeze_a: assert property ( // R12
    !clk_en_i |=> s_q == $past(s_q))
    else $error("State changed while clock enable was low.");

  dout_next_a: assert property ( // R03
    clk_en_i && fall_w && s_q.phase == SADC_SHIFT_OUT && s_q.out_cnt < `SADC_OUT_LAST
    |=> dout_o == $past(s_q.res_sr[`SADC_DATA_W-2]))
    else $error("Serial output did not advance to the next result bit.");

  dout_tail_a: assert property ( // R03
    clk_en_i && fall_w && s_q.phase == SADC_SHIFT_OUT && s_q.out_cnt == `SADC_OUT_LAST
    |=> dout_o == 1'b0)
    else $error("Serial output not low after the last result bit.");

  ext_rise_a: assert property ( // R06
    $rose(conversion_strobe_o) && s_q.ext_mode
    |-> $past(fall_w) && $past(s_q.bit_cnt) == `SADC_CTRL_BITS)
    else $error("External-mode strobe rose away from conversion start.");

  ext_busy_a: assert property ( // R06
    s_q.phase == SADC_EXT_CONV |-> conversion_strobe_o)
    else $error("External-mode strobe low during its pulse.");

  int_fall_a: assert property ( // R05
    $fell(conversion_strobe_o) && !s_q.ext_mode
    |-> s_q.phase == SADC_INT_CONV && $past(s_q.bit_cnt) == `SADC_CTRL_BITS)
    else $error("Internal-mode strobe fell away from conversion start.");

  ctrl_byte_a: assert property ( // R01
    $rose(control_valid_o) |-> control_byte_o == $past(s_q.ctrl_sr))
    else $error("Control byte does not hold the shifted bits.");

  cs_hold_a: assert property ( // R02
    clk_en_i && cs_s && s_q.phase != SADC_INT_CONV |=> s_q.ctrl_sr == $past(s_q.ctrl_sr))
    else $error("Input bits shifted while chip select high.");

  shutdown_idle_a: assert property ( // R09
    clk_en_i && s_q.full_sd |=> s_q.phase == SADC_IDLE && !track_o)
    else $error("Activity continued during full shutdown.");

  int_keep_a: assert property ( // R05
    clk_en_i && s_q.phase == SADC_INT_CONV && !int_done_w && !s_q.full_sd
    |=> s_q.phase == SADC_INT_CONV)
    else $error("Internal conversion left early.");

  conv_step_a: assert property ( // R12
    clk_en_i && s_q.phase == SADC_INT_CONV && !int_done_w && !s_q.full_sd
    |=> s_q.conv_cnt == $past(s_q.conv_cnt) + `SADC_CONV_CNT_W'(1))
    else $error("Conversion counter did not advance.");
endmodule

// *** shared/sadc_map.svh ***
// Named constants for the serial converter interface.
`ifndef SADC_MAP_SVH
`define SADC_MAP_SVH
`define SADC_DATA_W 8
`define SADC_BIT_CNT_W 4
`define SADC_CTRL_BITS 4'h8
`define SADC_TRACK_BIT 4'h6
`define SADC_STROBE_PERIODS 2'h2
`define SADC_OUT_LAST 4'h7
`define SADC_CONV_CNT_W 16
`define SADC_CLK_PERIOD_NS 10
`define SADC_CONV_TIME_NS 7500
`define SADC_THREE_LEVEL_SHUTDOWN_INPUT_LOW 2'h0
`define SADC_THREE_LEVEL_SHUTDOWN_INPUT_MID 2'h1
`define SADC_THREE_LEVEL_SHUTDOWN_INPUT_HIGH 2'h2
`define SADC_SYNC_W 5
// Synchroniser reset shows chip select high and shutdown floating, so no false shutdown follows.
`define SADC_SYNC_RST 5'h09
`endif

// *** shared/sadc_pkg.sv ***
// Types shared by the serial converter interface.
`include "sadc_map.svh"
package sadc_pkg;
  typedef enum logic [2:0] {
    SADC_IDLE,
    SADC_EXT_CONV,
    SADC_INT_CONV,
    SADC_SHIFT_OUT
  } sadc_phase_t;

  typedef struct packed {
    sadc_phase_t phase;
    logic [`SADC_BIT_CNT_W-1:0] bit_cnt;
    logic [`SADC_DATA_W-1:0] ctrl_sr;
    logic [`SADC_DATA_W-1:0] res_sr;
    logic [`SADC_BIT_CNT_W-1:0] out_cnt;
    logic [1:0] pulse_cnt;
    logic [`SADC_CONV_CNT_W-1:0] conv_cnt;
    logic sclk_p;
    logic ext_mode;
    logic strobe;
    logic track;
    logic dout;
    logic dout_oe_n;
    logic full_sd;
    logic ref_pd;
    logic [`SADC_DATA_W-1:0] ctrl_byte;
    logic ctrl_valid;
  } sadc_state_t;
endpackage

// *** hw/sadc_sync.sv ***
// Two-stage synchroniser for the pin inputs of the converter interface.
`timescale 1ns/1ns
module sadc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_q <= RST;
      sync_q <= RST;
    end else if (clk_en_i) begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule

// *** testbench/sadc_host.sv ***
// Host serial controller model driving the converter's serial pins.
`timescale 1ns/1ns
module sadc_host (
  input wire logic clock_i,
  input wire logic dout_i,
  input wire logic strobe_i,
  input wire logic probe_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic din_o
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    din_o = 1'b0;
  end
  task automatic select(input logic lvl);
    @(negedge clock_i);
    cs_n_o = lvl;
    if (lvl) begin
      din_o = ~din_o;
    end
    repeat (12) @(negedge clock_i);
  endtask
  // The serial clock stands still low between bursts, as a real host leaves it.
  task automatic burst(input int n, input logic [31:0] tx, output logic [31:0] rx,
                       output logic [31:0] sb, output logic [31:0] pb);
    rx = '0;
    sb = '0;
    pb = '0;
    for (int i = n - 1; i >= 0; i--) begin
      din_o = tx[i];
      repeat (6) @(negedge clock_i);
      rx = {rx[30:0], dout_i};
      sb = {sb[30:0], strobe_i};
      pb = {pb[30:0], probe_i};
      sclk_o = 1'b1;
      repeat (6) @(negedge clock_i);
      sclk_o = 1'b0;
    end
    repeat (6) @(negedge clock_i);
  endtask
endmodule

// *** testbench/sadc_core_tb.sv ***
// Self-checking bench for the serial converter interface.
`timescale 1ns/1ns
module sadc_core_tb;
  localparam int CONV = 40;
  logic clock_i = 1'b0;
  logic reset_n = 1'b0;
  logic cs_n, sclk, din, int_mode, dout, dout_oe_n, strobe, strobe_oe_n;
  logic track, full_sd, ref_off, ctrl_valid;
  logic clk_en;
  logic [1:0] three_level_shutdown_input_lvl;
  logic [7:0] sample;
  logic [7:0] ctrl_byte, first_cb;
  int num_errors = 0;
  int checks = 0;
  int nvalid = 0;
  int low_cnt = 0;
  always #5 clock_i = ~clock_i;
  sadc_core #(.CONV_CYCLES(CONV)) dut_u (
    .clock_i(clock_i), .reset_n_i(reset_n), .clk_en_i(clk_en), .cs_n_i(cs_n),
    .sclk_i(sclk), .din_i(din), .shutdown_level_i(three_level_shutdown_input_lvl),
    .int_clock_mode_i(int_mode), .sample_data_i(sample), .dout_o(dout),
    .dout_oe_n_o(dout_oe_n), .conversion_strobe_o(strobe),
    .conversion_strobe_oe_n_o(strobe_oe_n), .track_o(track),
    .full_shutdown_o(full_sd), .reference_generator_off_o(ref_off),
    .control_byte_o(ctrl_byte), .control_valid_o(ctrl_valid));
  sadc_host host_u (
    .clock_i(clock_i), .dout_i(dout), .strobe_i(strobe), .probe_i(track),
    .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din));
  // Conversion length is counted from the start pulse, so idle strobe levels do not matter.
  always @(posedge clock_i) begin
    if (ctrl_valid === 1'b1) begin
      if (nvalid == 0) first_cb = ctrl_byte;
      nvalid++;
      low_cnt = 1;
    end else if (strobe === 1'b0) begin
      low_cnt++;
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    if (num_errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic t_three_level_shutdown_input;
    logic [1:0] exp [3] = '{2'b10, 2'b00, 2'b01};
    for (int i = 0; i < 3; i++) begin
      three_level_shutdown_input_lvl = 2'(i);
      repeat (5) @(negedge clock_i);
      check("shutdown outputs", {full_sd, ref_off}, exp[i]);
    end
    three_level_shutdown_input_lvl = 2'h1;
  endtask
  // Clock enable low must freeze the synchronisers and the shutdown outputs alike.
  task automatic t_freeze;
    clk_en = 1'b0;
    three_level_shutdown_input_lvl = 2'h0;
    repeat (5) @(negedge clock_i);
    check("frozen shutdown", full_sd, 1'b0);
    clk_en = 1'b1;
    repeat (5) @(negedge clock_i);
    check("released shutdown", full_sd, 1'b1);
    three_level_shutdown_input_lvl = 2'h1;
    repeat (5) @(negedge clock_i);
  endtask
  task automatic t_ext;
    logic [31:0] rx, sb, pb;
    int_mode = 1'b0;
    sample = 8'hA5;
    nvalid = 0;
    host_u.burst(8, 32'hFF, rx, sb, pb);
    host_u.select(1'b0);
    host_u.burst(5, 32'h1F, rx, sb, pb);
    host_u.select(1'b1);
    host_u.select(1'b0);
    host_u.burst(18, {14'h0, 8'h8E, 10'h000}, rx, sb, pb);
    check("control byte", first_cb, 8'h8E);
    check("result", rx[7:0], 8'hA5);
    check("strobe pulse", sb[9:7], 3'b110);
    check("track window", pb[11:9], 3'b110);
    check("dout enable low", dout_oe_n, 1'b0);
    host_u.select(1'b1);
    check("dout enable high", dout_oe_n, 1'b1);
    check("strobe enable ext", strobe_oe_n, 1'b1);
  endtask
  task automatic t_int;
    logic [31:0] rx, sb, pb;
    int n;
    int_mode = 1'b1;
    sample = 8'h3C;
    host_u.select(1'b0);
    host_u.burst(8, 32'h9F, rx, sb, pb);
    check("strobe busy", strobe, 1'b0);
    // Results are not clocked until the strobe has risen.
    for (n = 0; n < 4 * CONV && strobe !== 1'b1; n++) @(negedge clock_i);
    if (strobe !== 1'b1) begin
      num_errors++;
      wrap_up();
    end
    check("conversion cycles", low_cnt, CONV);
    host_u.burst(8, 32'h0, rx, sb, pb);
    check("result", rx[7:0], 8'h3C);
    host_u.select(1'b1);
    check("strobe enable int", strobe_oe_n, 1'b0);
  endtask
  initial begin
    int_mode = 1'b1;
    clk_en = 1'b1;
    three_level_shutdown_input_lvl = 2'h1;
    sample = 8'h00;
    repeat (6) @(negedge clock_i);
    reset_n = 1'b1;
    repeat (4) @(negedge clock_i);
    t_three_level_shutdown_input();
    t_freeze();
    t_ext();
    t_int();
    wrap_up();
  end
endmodule
